// ### src/ubr_pkg.sv
package ubr_pkg;
   // Register indices on the plain port
   localparam logic [2:0] A_CTL1 = 3'h0;
   localparam logic [2:0] A_CTL2 = 3'h1;
   localparam logic [2:0] A_CTL3 = 3'h2;
   localparam logic [2:0] A_STS1 = 3'h3;
   localparam logic [2:0] A_STS2 = 3'h4;
   localparam logic [2:0] A_DATA = 3'h5;
   localparam logic [2:0] A_BAUD = 3'h6;
   localparam logic [2:0] A_BDIV = 3'h7;
   // Field positions
   localparam int B_INV  = 5; // control_one
   localparam int B_LEN  = 4;
   localparam int B_TEIE = 7; // control_two
   localparam int B_TX_COMPLETE_IRQ_EN = 6;
   localparam int B_RFIE = 5;
   localparam int B_TE   = 3;
   localparam int B_SBK  = 0;
   localparam int B_R9   = 7; // control_three
   localparam int B_T9   = 6;
   localparam int B_TBE  = 7; // status_one
   localparam int B_TC   = 6;
   localparam int B_RF   = 5;
   localparam int B_OVR  = 3;
   localparam int B_NF   = 2;
   localparam int B_FE   = 1;
   localparam int B_BRK  = 1; // status_two
   localparam int B_RIP  = 0;
   localparam int B_LBR  = 6; // baud_config
   // Character timing in oversample ticks and bits, plus status_one reset value
   localparam logic [3:0] RT_LAST = 4'hF;
   localparam logic [4:0] RT_ONE  = 5'h01;
   localparam logic [4:0] RT_S1   = 5'h03;
   localparam logic [4:0] RT_S2   = 5'h05;
   localparam logic [4:0] RT_S3   = 5'h07;
   localparam logic [4:0] RT_V1   = 5'h08;
   localparam logic [4:0] RT_V3   = 5'h0A;
   localparam logic [4:0] RT_RSY  = 5'h0B;
   localparam logic [4:0] RT_END  = 5'h10;
   localparam logic [3:0] LEN8    = 4'hA;
   localparam logic [3:0] LEN9    = 4'hB;
   localparam logic [3:0] ND8     = 4'h8;
   localparam logic [3:0] ND9     = 4'h9;
   localparam logic [7:0] RST_STS1 = 8'hC0;

   typedef struct packed {
      logic inv;
      logic len9;
      logic tbe_ie;
      logic tc_ie;
      logic rf_ie;
      logic te;
      logic send_break;
      logic t9;
      logic lbr;
   } ubr_ctl_s;

   typedef enum {TX_IDLE, TX_PRE, TX_DATA, TX_BREAK, TX_MARK} ubr_tx_e;
   typedef enum {RX_SEARCH, RX_FRAME} ubr_rx_e;
endpackage

// ### src/ubr_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - While send_break is set, keep reloading all-zero break characters of selected length.
// - After send_break clears, finish the break, then send at least one 1 bit.
// - Break recognised at 10/11 zeros, or 11/12 zeros with long_break_rx set.
// - Break sets framing error, rx_full, break_flag; clears data_buffer and rx_ninth_bit.
// - Idle character is all ones of selected length; setting tx_enable sends one before any data.
// - Clearing tx_enable mid-character finishes that character, then holds the line idle.
// - Clearing then setting tx_enable mid-transmission queues one idle character next.
// - tx_invert inverts every transmitted level, idle and break included.
// - tx_buffer_empty sets on buffer-to-shifter transfer; interrupt when enabled.
// - tx_complete_flag when shifter and buffer empty and nothing generated; interrupt when enabled.
// - Completed character moves to the read buffer and sets rx_full; interrupt when enabled.
// - Receiver samples the input on oversample_tick at sixteen times the baud rate.
// - Oversample count resyncs after start bit and after a 1-to-0 data transition.
// - Start search looks for 0 after three 1s; count to 16 begins at the edge.
// - Start verified by samples 3,5,7: at most one 1; one 1 sets noise.
// - Data bit is majority of samples 8,9,10; disagreement sets noise.
// - Ones in start samples 8,9,10 after verification set noise only.
// - Stop bit from samples 8,9,10: majority zero is framing error, disagreement noise.
// - Framing error when stop position lacks a 1, set together with rx_full.
module ubr_top
   import ubr_pkg::*;
(
   input  wire logic       clk_sys_i, // 200 MHz system clock
   input  wire logic       rstn_i,    // Async reset, active low
   input  wire logic [2:0] addr_i,    // Register index
   input  wire logic [7:0] wdata_i,   // Write data
   input  wire logic       we_i,      // Write strobe
   input  wire logic       re_i,      // Read strobe
   output logic      [7:0] rdata_o,   // Read data, cycle after strobe
   input  wire logic       rxd_i,     // Serial input
   output logic            txd_o,     // Serial output
   output logic            tx_irq_o,  // Transmitter request
   output logic            rx_irq_o   // Receiver request
);
   ubr_ctl_s    ctl_ff;
   logic [7:0]  bdiv_ff;
   logic [7:0]  dcnt_ff;
   logic        tick;
   logic        wr_data;
   logic        rd_data;
   // Transmitter
   ubr_tx_e     tx_st_ff;
   logic [10:0] tsh_ff;
   logic [3:0]  trt_ff;
   logic [3:0]  tbit_ff;
   logic [3:0]  tlen_ff;
   logic [7:0]  tbuf_ff;
   logic        tb9_ff;
   logic        tbe_ff;
   logic        tc_ff;
   logic        te_d_ff;
   logic        qidle_ff;
   logic        tline_ff;
   logic        tdone;
   logic        tload;
   // Receiver
   ubr_rx_e     rx_st_ff;
   logic [2:0]  hist_ff;
   logic [4:0]  rrt_ff;
   logic [3:0]  rbit_ff;
   logic [1:0]  vote_ff;
   logic [1:0]  ones_ff;
   logic [8:0]  rsh_ff;
   logic        allz_ff;
   logic        last1_ff;
   logic [7:0]  dbuf_ff;
   logic        r9_ff;
   logic        rf_ff;
   logic        fe_ff;
   logic        nf_ff;
   logic        ovr_ff;
   logic        brk_ff;
   logic [2:0]  v3;
   logic        maj;
   logic        dis;
   logic [3:0]  nd;
   logic        rdone;
   logic        rbrk;
   logic        rnoise;
   logic        sync_fall;

   assign wr_data = we_i && (addr_i == A_DATA);
   assign rd_data = re_i && (addr_i == A_DATA);

   // Register writes
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctl_ff  <= '0;
         bdiv_ff <= '0;
      end else if (we_i) begin
         if (addr_i == A_CTL1) begin
            ctl_ff.inv  <= wdata_i[B_INV];
            ctl_ff.len9 <= wdata_i[B_LEN];
         end else if (addr_i == A_CTL2) begin
            ctl_ff.tbe_ie <= wdata_i[B_TEIE];
            ctl_ff.tc_ie  <= wdata_i[B_TX_COMPLETE_IRQ_EN];
            ctl_ff.rf_ie  <= wdata_i[B_RFIE];
            ctl_ff.te     <= wdata_i[B_TE];
            ctl_ff.send_break    <= wdata_i[B_SBK];
         end else if (addr_i == A_CTL3) begin
            ctl_ff.t9 <= wdata_i[B_T9];
         end else if (addr_i == A_BAUD) begin
            ctl_ff.lbr <= wdata_i[B_LBR];
         end else if (addr_i == A_BDIV) begin
            bdiv_ff <= wdata_i;
         end
      end
   end

   // Register reads, unmapped bits read zero
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= '0;
      end else if (re_i) begin
         rdata_o <= '0;
         if (addr_i == A_CTL1) begin
            rdata_o[B_INV] <= ctl_ff.inv;
            rdata_o[B_LEN] <= ctl_ff.len9;
         end else if (addr_i == A_CTL2) begin
            rdata_o[B_TEIE] <= ctl_ff.tbe_ie;
            rdata_o[B_TX_COMPLETE_IRQ_EN] <= ctl_ff.tc_ie;
            rdata_o[B_RFIE] <= ctl_ff.rf_ie;
            rdata_o[B_TE]   <= ctl_ff.te;
            rdata_o[B_SBK]  <= ctl_ff.send_break;
         end else if (addr_i == A_CTL3) begin
            rdata_o[B_R9] <= r9_ff;
            rdata_o[B_T9] <= ctl_ff.t9;
         end else if (addr_i == A_STS1) begin
            rdata_o[B_TBE] <= tbe_ff;
            rdata_o[B_TC]  <= tc_ff;
            rdata_o[B_RF]  <= rf_ff;
            rdata_o[B_OVR] <= ovr_ff;
            rdata_o[B_NF]  <= nf_ff;
            rdata_o[B_FE]  <= fe_ff;
         end else if (addr_i == A_STS2) begin
            rdata_o[B_BRK] <= brk_ff;
            rdata_o[B_RIP] <= (rx_st_ff == RX_FRAME);
         end else if (addr_i == A_DATA) begin
            rdata_o <= dbuf_ff;
         end else if (addr_i == A_BAUD) begin
            rdata_o[B_LBR] <= ctl_ff.lbr;
         end else begin
            rdata_o <= bdiv_ff;
         end
      end
   end

   // Oversample tick: one clock in bdiv+1
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dcnt_ff <= '0;
      end else if (dcnt_ff >= bdiv_ff) begin
         dcnt_ff <= '0;
      end else begin
         dcnt_ff <= dcnt_ff + 8'h01;
      end
   end
   assign tick = (dcnt_ff >= bdiv_ff);

   // Transmitter
   assign tdone = tick && (trt_ff == RT_LAST) && (tbit_ff == tlen_ff - 4'h1);
   // Enable edge and queued idle both take a preamble before any data
   assign tload = (tx_st_ff == TX_IDLE || tdone) && !ctl_ff.send_break && !(tx_st_ff == TX_BREAK)
                  && ctl_ff.te && !tbe_ff && !qidle_ff && !(ctl_ff.te && !te_d_ff);

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_st_ff <= TX_IDLE;
         tsh_ff   <= '1;
         trt_ff   <= '0;
         tbit_ff  <= '0;
         tlen_ff  <= LEN8;
         te_d_ff  <= 1'b0;
         qidle_ff <= 1'b0;
      end else begin
         te_d_ff <= ctl_ff.te;
         // Enable toggled mid-character: an idle goes out before further data
         if (ctl_ff.te && !te_d_ff && tx_st_ff != TX_IDLE) begin
            qidle_ff <= 1'b1;
         end
         if (tx_st_ff != TX_IDLE && tick) begin
            trt_ff <= trt_ff + 4'h1;
            if (trt_ff == RT_LAST) begin
               tbit_ff <= tbit_ff + 4'h1;
               // Break fills with zeros, or a 12-bit break would end high
               if (tx_st_ff == TX_BREAK) begin
                  tsh_ff <= {1'b0, tsh_ff[10:1]};
               end else begin
                  tsh_ff <= {1'b1, tsh_ff[10:1]};
               end
            end
         end
         if (tx_st_ff == TX_IDLE || tdone) begin
            trt_ff  <= '0;
            tbit_ff <= '0;
            tlen_ff <= ctl_ff.len9 ? LEN9 : LEN8;
            if (ctl_ff.send_break && ctl_ff.te) begin
               tx_st_ff <= TX_BREAK;
               tsh_ff   <= '0;
               tlen_ff  <= (ctl_ff.len9 ? LEN9 : LEN8) + {3'h0, ctl_ff.lbr};
            end else if (tx_st_ff == TX_BREAK) begin
               tx_st_ff <= TX_MARK;
               tsh_ff   <= '1;
               tlen_ff  <= 4'h1;
            end else if (!ctl_ff.te) begin
               tx_st_ff <= TX_IDLE;
               tsh_ff   <= '1;
            end else if (qidle_ff || !te_d_ff) begin
               tx_st_ff <= TX_PRE;
               tsh_ff   <= '1;
               qidle_ff <= 1'b0;
            end else if (tload) begin
               tx_st_ff <= TX_DATA;
               tsh_ff   <= {1'b1, ctl_ff.len9 ? tb9_ff : 1'b1, tbuf_ff, 1'b0};
            end else begin
               tx_st_ff <= TX_IDLE;
               tsh_ff   <= '1;
            end
         end
      end
   end

   // Transmit buffer and flags; a write in the load cycle refills it
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tbuf_ff <= '0;
         tb9_ff  <= 1'b0;
         tbe_ff  <= RST_STS1[B_TBE];
         tc_ff   <= RST_STS1[B_TC];
      end else begin
         if (wr_data) begin
            tbuf_ff <= wdata_i;
            tb9_ff  <= ctl_ff.t9;
            tbe_ff  <= 1'b0;
         end else if (tload) begin
            tbe_ff <= 1'b1;
         end
         tc_ff <= (tx_st_ff == TX_IDLE) && tbe_ff && !wr_data && !(ctl_ff.send_break && ctl_ff.te);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tline_ff <= 1'b1;
         txd_o    <= 1'b1;
         tx_irq_o <= 1'b0;
         rx_irq_o <= 1'b0;
      end else begin
         // Idle is forced high before inversion so both levels flip together
         tline_ff <= (tx_st_ff == TX_IDLE) ? 1'b1 : tsh_ff[0];
         txd_o    <= tline_ff ^ ctl_ff.inv;
         tx_irq_o <= (tbe_ff && ctl_ff.tbe_ie) || (tc_ff && ctl_ff.tc_ie);
         rx_irq_o <= rf_ff && ctl_ff.rf_ie;
      end
   end

   // Receiver data recovery
   assign v3        = {vote_ff, rxd_i};
   assign maj       = (v3[0] & v3[1]) | (v3[0] & v3[2]) | (v3[1] & v3[2]);
   assign dis       = (v3 != 3'h0) && (v3 != 3'h7);
   assign nd        = ctl_ff.len9 ? ND9 : ND8;
   // Early fall after a recovered 1 restarts the count, absorbing fast data
   assign sync_fall = last1_ff && hist_ff[0] && !rxd_i && (rrt_ff >= RT_RSY)
                      && (rbit_ff != 4'h0) && (rbit_ff <= nd);
   assign rdone     = tick && (rx_st_ff == RX_FRAME) && (rrt_ff == RT_V3)
                      && ((rbit_ff == nd + 4'h1 && (maj || !allz_ff || !ctl_ff.lbr))
                          || rbit_ff == nd + 4'h2);
   assign rbrk      = allz_ff && !maj;
   assign rnoise    = tick && (rx_st_ff == RX_FRAME) && (rrt_ff == RT_V3) &&
                      ((rbit_ff == 4'h0) ? (v3 != 3'h0) : dis);

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_st_ff <= RX_SEARCH;
         hist_ff  <= '0;
         rrt_ff   <= RT_ONE;
         rbit_ff  <= '0;
         vote_ff  <= '0;
         ones_ff  <= '0;
         rsh_ff   <= '0;
         allz_ff  <= 1'b1;
         last1_ff <= 1'b0;
      end else if (tick) begin
         hist_ff <= {hist_ff[1:0], rxd_i};
         if (rx_st_ff == RX_SEARCH) begin
            if (hist_ff == 3'h7 && !rxd_i) begin
               rx_st_ff <= RX_FRAME;
               rrt_ff   <= RT_ONE + 5'h01;
               rbit_ff  <= '0;
               ones_ff  <= '0;
               allz_ff  <= 1'b1;
               last1_ff <= 1'b0;
            end
         end else if (sync_fall) begin
            rrt_ff  <= RT_ONE + 5'h01;
            rbit_ff <= rbit_ff + 4'h1;
         end else begin
            rrt_ff <= (rrt_ff == RT_END) ? RT_ONE : rrt_ff + 5'h01;
            if (rrt_ff == RT_END) begin
               rbit_ff <= rbit_ff + 4'h1;
            end
            if (rbit_ff == 4'h0 && (rrt_ff == RT_S1 || rrt_ff == RT_S2)) begin
               ones_ff <= ones_ff + {1'b0, rxd_i};
            end
            // Cleared history forces three fresh marks before the next search
            if (rbit_ff == 4'h0 && rrt_ff == RT_S3 && (ones_ff + {1'b0, rxd_i}) > 2'h1) begin
               rx_st_ff <= RX_SEARCH;
               hist_ff  <= '0;
            end
            if (rrt_ff >= RT_V1 && rrt_ff < RT_V3) begin
               vote_ff <= {vote_ff[0], rxd_i};
            end
            if (rrt_ff == RT_V3 && rbit_ff != 4'h0 && rbit_ff <= nd) begin
               rsh_ff   <= {maj, rsh_ff[8:1]};
               allz_ff  <= allz_ff && !maj;
               last1_ff <= maj;
            end
            if (rdone) begin
               rx_st_ff <= RX_SEARCH;
               hist_ff  <= '0;
            end
         end
      end
   end

   // Receive buffer and flags; data read clears, hardware set wins
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dbuf_ff <= '0;
         r9_ff   <= 1'b0;
         rf_ff   <= 1'b0;
         fe_ff   <= 1'b0;
         nf_ff   <= 1'b0;
         ovr_ff  <= 1'b0;
         brk_ff  <= 1'b0;
      end else begin
         if (rd_data) begin
            rf_ff  <= 1'b0;
            fe_ff  <= 1'b0;
            nf_ff  <= 1'b0;
            ovr_ff <= 1'b0;
            brk_ff <= 1'b0;
         end
         if (rnoise || (tick && rx_st_ff == RX_FRAME && rbit_ff == 4'h0 && rrt_ff == RT_S3
                        && (ones_ff + {1'b0, rxd_i}) == 2'h1)) begin
            nf_ff <= 1'b1;
         end
         if (rdone) begin
            rf_ff <= 1'b1;
            if (rf_ff && !rd_data) begin
               ovr_ff <= 1'b1;
            end else if (rbrk) begin
               dbuf_ff <= '0;
               r9_ff   <= 1'b0;
            end else begin
               dbuf_ff <= ctl_ff.len9 ? rsh_ff[7:0] : rsh_ff[8:1];
               r9_ff   <= rsh_ff[8];
            end
            // Extra long-break bit is only reached after a low stop sample
            if (!maj || rbit_ff != nd + 4'h1) begin
               fe_ff <= 1'b1;
            end
            if (rbrk) begin
               brk_ff <= 1'b1;
            end
         end
      end
   end
endmodule // ubr_top

// ### verification/ubr_top_assertions.sv
`timescale 1ns/1ps
module ubr_top_chk
   import ubr_pkg::*;
(
   input  wire logic       clk_sys_i, // System clock
   input  wire logic       rstn_i,    // Async reset, active low
   input  wire logic [2:0] addr_i,    // Register index
   input  wire logic [7:0] wdata_i,   // Write data
   input  wire logic       we_i,      // Write strobe
   input  wire logic       re_i,      // Read strobe
   input  wire logic [7:0] rdata_o,   // Read data
   input  wire logic       rxd_i,     // Serial input
   input  wire logic       txd_o,     // Serial output
   input  wire logic       tx_irq_o,  // Transmitter request
   input  wire logic       rx_irq_o   // Receiver request
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   logic [7:0] ctl2_ff;
   logic       inv_ff;
   logic [3:0] acc_ff;
   logic [9:0] quiet_ff;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctl2_ff <= 8'h00;
         inv_ff  <= 1'b0;
      end else if (we_i && addr_i == A_CTL2) begin
         ctl2_ff <= wdata_i;
      end else if (we_i && addr_i == A_CTL1) begin
         inv_ff <= wdata_i[B_INV];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) acc_ff <= 4'h0;
      else acc_ff <= {acc_ff[2:0], we_i | re_i};
   end

   // Assumes divider 0..4: a slower line could outlast this count
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) quiet_ff <= 10'h000;
      else if (ctl2_ff[B_TE] || ctl2_ff[B_SBK]) quiet_ff <= 10'h000;
      else if (quiet_ff != 10'h3FF) quiet_ff <= quiet_ff + 10'h001;
   end

   sequence line_quiet;
      quiet_ff == 10'h3FF && inv_ff == $past(inv_ff, 3);
   endsequence

   reset_idle_a: assert property ($rose(rstn_i) |-> txd_o && !tx_irq_o && !rx_irq_o)
      else $error("line or requests not idle after reset");
   read_hold_a: assert property (!$past(re_i) |-> $stable(rdata_o))
      else $error("read data changed without a read");
   rx_irq_drop_a: assert property ($fell(rx_irq_o) |-> acc_ff != 4'h0)
      else $error("receive request dropped without host access");
   tx_irq_drop_a: assert property ($fell(tx_irq_o) |-> acc_ff != 4'h0)
      else $error("transmit request dropped without host access");
   rx_irq_gate_a: assert property ($rose(rx_irq_o) |-> ctl2_ff[B_RFIE])
      else $error("receive request while masked");
   tx_irq_gate_a: assert property ($rose(tx_irq_o) |-> ctl2_ff[B_TEIE] || ctl2_ff[B_TX_COMPLETE_IRQ_EN])
      else $error("transmit request while masked");
   rx_mask_a: assert property (we_i && addr_i == A_CTL2 && !wdata_i[B_RFIE] |-> ##[1:3] !rx_irq_o)
      else $error("receive request not masked");
   quiet_line_a: assert property (line_quiet |-> txd_o != inv_ff)
      else $error("disabled transmitter not at idle level");
endmodule // ubr_top_chk

bind ubr_top ubr_top_chk chk_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o), .tx_irq_o(tx_irq_o),
   .rx_irq_o(rx_irq_o));

// ### verification/ubr_far_end.sv
`timescale 1ns/1ps
module ubr_far_end (
   input  wire logic clk_i, // Shared clock, divider left at 0
   input  wire logic txd_i, // Line from the block
   output logic      rxd_o  // Line into the block
);
   initial rxd_o = 1'b1;

   // One bit is 16 clocks; mk flips single clocks of bit nb to model noise
   task automatic send(input logic [11:0] fr, input int n, input int nb, input logic [15:0] mk);
      for (int i = 0; i < n; i++) begin
         for (int j = 0; j < 16; j++) begin
            @(posedge clk_i);
            rxd_o <= fr[i] ^ (i == nb && mk[j]);
         end
      end
      @(posedge clk_i);
      rxd_o <= 1'b1;
      // Three marks so the next start search can begin
      repeat (48) @(posedge clk_i);
   endtask

   task automatic recv(input int n, output logic [11:0] fr, output int t);
      t  = 0;
      fr = 12'h000;
      while (txd_i !== 1'b0 && t < 2000) begin
         @(posedge clk_i);
         #1;
         t++;
      end
      repeat (8) @(posedge clk_i);
      #1;
      for (int i = 0; i < n; i++) begin
         fr[i] = txd_i;
         repeat (16) @(posedge clk_i);
         #1;
      end
   endtask
endmodule // ubr_far_end

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
   import ubr_pkg::*;
   logic       clk_sys_i;
   logic       rstn_i;
   logic [2:0] addr_i;
   logic [7:0] wdata_i;
   logic       we_i;
   logic       re_i;
   logic [7:0] rdata_o;
   logic       rxd_i;
   logic       txd_o;
   logic       tx_irq_o;
   logic       rx_irq_o;
   int         errors;
   int         n_compared;

   always #2.5 clk_sys_i = ~clk_sys_i;

   ubr_top dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
      .re_i(re_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
   ubr_far_end far_u (.clk_i(clk_sys_i), .txd_i(txd_o), .rxd_o(rxd_i));

   task automatic stop_test();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i  <= a;
      wdata_i <= d;
      we_i    <= 1'b1;
      @(posedge clk_sys_i);
      we_i <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      re_i   <= 1'b1;
      @(posedge clk_sys_i);
      re_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   task automatic hold_line(input logic lvl, input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(posedge clk_sys_i);
         #1;
         if (txd_o !== lvl) bad = 1'b1;
      end
      chk({11'h000, bad}, 12'h000, "line level");
   endtask

   task automatic bound(input int t, input int lim);
      if (t >= lim) begin
         errors++;
         $display("unexpected at %0t: wait ran out", $time);
         stop_test();
      end
   endtask

   task automatic wait_line(input logic lvl);
      int t;
      t = 0;
      while (txd_o !== lvl && t < 600) begin
         @(posedge clk_sys_i);
         #1;
         t++;
      end
      bound(t, 600);
   endtask

   task automatic rx_case(input logic [11:0] fr, input int n, input int nb, input logic [15:0] mk,
                          input logic [7:0] sm, input logic [7:0] se, input logic [7:0] de, input logic r9,
                          input logic bk);
      logic [7:0] v;
      int         t;
      far_u.send(fr, n, nb, mk);
      t = 0;
      while (rx_irq_o !== 1'b1 && t < 600) begin
         @(posedge clk_sys_i);
         t++;
      end
      bound(t, 600);
      chk({11'h000, rx_irq_o}, 12'h001, "receive request");
      rd(A_STS1, v);
      chk({4'h0, v & sm}, {4'h0, se}, "status one");
      rd(A_STS2, v);
      chk({11'h000, v[B_BRK]}, {11'h000, bk}, "break flag");
      rd(A_CTL3, v);
      chk({11'h000, v[B_R9]}, {11'h000, r9}, "ninth bit");
      rd(A_DATA, v);
      chk({4'h0, v}, {4'h0, de}, "data");
   endtask

   task automatic s_reset();
      logic [7:0] v;
      rd(A_STS1, v);
      chk({4'h0, v}, {4'h0, RST_STS1}, "status one");
      rd(A_STS2, v);
      chk({4'h0, v}, 12'h000, "status two");
   endtask

   task automatic s_rx();
      logic [7:0] v;
      wr(A_CTL2, 8'h20);
      rx_case({2'b00, 1'b1, 8'hA5, 1'b0}, 10, -1, 16'h0000, 8'h2E, 8'h20, 8'hA5, 1'b1, 1'b0);
      rd(A_STS1, v);
      chk({11'h000, v[B_RF]}, 12'h000, "full after read");
      rx_case({2'b00, 1'b1, 8'h5A, 1'b0}, 10, 0, 16'h0030, 8'h2E, 8'h24, 8'h5A, 1'b0, 1'b0);
      rx_case({2'b00, 1'b1, 8'h5A, 1'b0}, 10, 0, 16'h0100, 8'h2E, 8'h24, 8'h5A, 1'b0, 1'b0);
      rx_case({2'b00, 1'b1, 8'h5A, 1'b0}, 10, 3, 16'h0100, 8'h2E, 8'h24, 8'h5A, 1'b0, 1'b0);
      rx_case({2'b00, 1'b1, 8'h5A, 1'b0}, 10, 9, 16'h0100, 8'h2E, 8'h24, 8'h5A, 1'b0, 1'b0);
      rx_case({2'b00, 1'b0, 8'h81, 1'b0}, 10, -1, 16'h0000, 8'h22, 8'h22, 8'h81, 1'b1, 1'b0);
      far_u.send(12'h000, 1, 0, 16'hFFFC);
      rd(A_STS1, v);
      chk({11'h000, v[B_RF]}, 12'h000, "rejected start");
      rx_case({2'b00, 1'b1, 8'hBC, 1'b0}, 10, -1, 16'h0000, 8'h2E, 8'h20, 8'hBC, 1'b1, 1'b0);
      rx_case(12'h000, 11, -1, 16'h0000, 8'h22, 8'h22, 8'h00, 1'b0, 1'b1);
      wr(A_BAUD, 8'h40);
      rx_case(12'h000, 10, -1, 16'h0000, 8'h2E, 8'h22, 8'h00, 1'b0, 1'b0);
      rx_case(12'h000, 12, -1, 16'h0000, 8'h22, 8'h22, 8'h00, 1'b0, 1'b1);
      wr(A_BAUD, 8'h00);
      wr(A_CTL1, 8'h10);
      rx_case({1'b0, 1'b1, 1'b1, 8'h0F, 1'b0}, 11, -1, 16'h0000, 8'h2E, 8'h20, 8'h0F, 1'b1, 1'b0);
      wr(A_CTL1, 8'h00);
   endtask

   task automatic s_tx();
      logic [7:0]  v;
      logic [11:0] fr;
      int          t;
      wr(A_CTL2, 8'h08);
      wr(A_DATA, 8'h3C);
      rd(A_STS1, v);
      chk({4'h0, v & 8'hC0}, 12'h000, "busy flags");
      far_u.recv(10, fr, t);
      bound(t, 2000);
      chk({11'h000, t >= 150}, 12'h001, "preamble length");
      chk(fr, {2'b00, 1'b1, 8'h3C, 1'b0}, "frame");
      wr(A_CTL2, 8'hC8);
      repeat (4) @(posedge clk_sys_i);
      rd(A_STS1, v);
      chk({4'h0, v & 8'hC0}, 12'h0C0, "empty flags");
      chk({11'h000, tx_irq_o}, 12'h001, "transmit request");
      wr(A_CTL2, 8'h08);
      wr(A_DATA, 8'h96);
      fork
         far_u.recv(10, fr, t);
         begin
            repeat (60) @(posedge clk_sys_i);
            wr(A_CTL2, 8'h00);
         end
      join
      bound(t, 2000);
      chk(fr, {2'b00, 1'b1, 8'h96, 1'b0}, "frame finished");
      hold_line(1'b1, 200);
   endtask

   task automatic s_break();
      logic [11:0] fr;
      int          t;
      wr(A_CTL2, 8'h09);
      far_u.recv(12, fr, t);
      bound(t, 2000);
      chk(fr, 12'h000, "break first");
      far_u.recv(12, fr, t);
      bound(t, 2000);
      chk(fr, 12'h000, "break reload");
      wr(A_DATA, 8'h55);
      wr(A_CTL2, 8'h08);
      wait_line(1'b1);
      hold_line(1'b1, 14);
      far_u.recv(10, fr, t);
      bound(t, 2000);
      chk(fr, {2'b00, 1'b1, 8'h55, 1'b0}, "frame after break");
      wr(A_DATA, 8'h33);
      fork
         far_u.recv(10, fr, t);
         begin
            wr(A_DATA, 8'hCC);
            wr(A_CTL2, 8'h00);
            wr(A_CTL2, 8'h08);
         end
      join
      bound(t, 2000);
      chk(fr, {2'b00, 1'b1, 8'h33, 1'b0}, "frame before idle");
      far_u.recv(10, fr, t);
      bound(t, 2000);
      chk({11'h000, t >= 140}, 12'h001, "queued idle");
      chk(fr, {2'b00, 1'b1, 8'hCC, 1'b0}, "frame after idle");
   endtask

   task automatic s_invert();
      wr(A_CTL2, 8'h00);
      repeat (1100) @(posedge clk_sys_i);
      wr(A_CTL1, 8'h20);
      repeat (4) @(posedge clk_sys_i);
      hold_line(1'b0, 32);
      wr(A_CTL2, 8'h08);
      hold_line(1'b0, 100);
      wr(A_CTL2, 8'h00);
      wr(A_CTL1, 8'h00);
   endtask

   initial begin
      clk_sys_i  = 1'b0;
      rstn_i     = 1'b0;
      addr_i     = 3'h0;
      wdata_i    = 8'h00;
      we_i       = 1'b0;
      re_i       = 1'b0;
      errors     = 0;
      n_compared = 0;
      repeat (5) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      s_reset();
      s_rx();
      s_tx();
      s_break();
      s_invert();
      stop_test();
   end
endmodule // tb
